// ==== rtl/tx_multiphy_address_table.sv ====
// transmit multi-phy address table with axi4-lite register access
`timescale 1ns/1ps
`include "txmp_defs.svh"

module tx_multiphy_address_table (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [15:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [15:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic [4:0]  TX_BUS_ADDR,
  input  wire logic [3:0]  TX_CELL_ROOM,
  output logic             TX_CLAV,
  output logic             TX_CLAV_OEN,
  output logic [1:0]       TX_MATCH_CHAN
);

  txmp_pkg::addr_hold_t aw;
  txmp_pkg::data_hold_t wd;
  txmp_pkg::tx_addr_t   table_mem [4];
  logic [7:0]           ctrl;
  logic [4:0]           chan_ptr;
  logic                 do_write;
  txmp_pkg::reg_sel_t   wsel;
  txmp_pkg::match_t     next_match;

  function automatic txmp_pkg::reg_sel_t decode(input logic [15:0] a);
    if (a == `TXMP_BYTE(`TXMP_CTRL_IDX))
      return txmp_pkg::SEL_CTRL;
    else if (a == `TXMP_BYTE(`TXMP_ADDR_IDX))
      return txmp_pkg::SEL_ADDR;
    else if (a == `TXMP_BYTE(`TXMP_PTR_IDX))
      return txmp_pkg::SEL_PTR;
    else
      return txmp_pkg::SEL_NONE;
  endfunction : decode

  assign do_write = aw.held && wd.held && !BVALID;
  assign wsel     = decode(aw.addr);

  // write channel: address and data taken in either order, one write at a time
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw      <= '0;
      wd      <= '0;
      AWREADY <= 1'b1;
      WREADY  <= 1'b1;
      BVALID  <= 1'b0;
      BRESP   <= `TXMP_RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw      <= '{held: 1'b1, addr: AWADDR};
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        wd     <= '{held: 1'b1, data: WDATA, strb: WSTRB};
        WREADY <= 1'b0;
      end
      if (do_write) begin
        aw.held <= 1'b0;
        wd.held <= 1'b0;
        BVALID  <= 1'b1;
        BRESP   <= (wsel == txmp_pkg::SEL_NONE) ? `TXMP_RESP_SLVERR
                                                : `TXMP_RESP_OKAY;
      end else if (BVALID && BREADY) begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  // control and pointer; only byte lane 0 carries register bits
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl     <= `TXMP_CTRL_RESET;
      chan_ptr <= `TXMP_PTR_RESET;
    end else if (do_write && wd.strb[0]) begin
      if (wsel == txmp_pkg::SEL_CTRL)
        ctrl <= wd.data[7:0];
      if (wsel == txmp_pkg::SEL_PTR)
        chan_ptr <= wd.data[4:0];
    end
  end

  // unassigned entries hold all-ones, a value software may never use,
  // so an unconfigured channel never answers a poll in multi-phy mode
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < `TXMP_CHANNELS; i++)
        table_mem[i] <= `TXMP_UNASSIGNED;
    end else if (do_write && wd.strb[0] && wsel == txmp_pkg::SEL_ADDR
                 && chan_ptr <= `TXMP_PTR_MAX) begin
      table_mem[chan_ptr[1:0]] <= wd.data[4:0];
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= `TXMP_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RRESP   <= `TXMP_RESP_OKAY;
      case (decode(ARADDR))
        txmp_pkg::SEL_CTRL: RDATA <= {24'h00_0000, ctrl};
        txmp_pkg::SEL_PTR:  RDATA <= {27'h000_0000, chan_ptr};
        txmp_pkg::SEL_ADDR: RDATA <= (chan_ptr <= `TXMP_PTR_MAX) ?
                              {27'h000_0000, table_mem[chan_ptr[1:0]]} :
                              32'h0000_0000;
        default: begin
          RDATA <= 32'h0000_0000;
          RRESP <= `TXMP_RESP_SLVERR;
        end
      endcase
    end else if (RVALID && RREADY) begin
      RVALID  <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // address match; lowest channel wins if software broke uniqueness
  always_comb begin
    next_match = '0;
    if (TX_BUS_ADDR != `TXMP_UNASSIGNED) begin
      for (int i = `TXMP_CHANNELS - 1; i >= 0; i--) begin
        if (table_mem[i] == TX_BUS_ADDR) begin
          next_match.hit  = 1'b1;
          next_match.chan = 2'(i);
        end
      end
    end
  end

  // single-phy mode drives cell-available from channel 0 without polling
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TX_CLAV       <= 1'b0;
      TX_CLAV_OEN   <= 1'b1;
      TX_MATCH_CHAN <= 2'h0;
    end else if (!ctrl[`TXMP_MPHY_BIT]) begin
      TX_CLAV       <= TX_CELL_ROOM[0];
      TX_CLAV_OEN   <= 1'b0;
      TX_MATCH_CHAN <= 2'h0;
    end else if (next_match.hit) begin
      TX_CLAV       <= TX_CELL_ROOM[next_match.chan];
      TX_CLAV_OEN   <= 1'b0;
      TX_MATCH_CHAN <= next_match.chan;
    end else begin
      TX_CLAV       <= 1'b0;
      TX_CLAV_OEN   <= 1'b1;
      TX_MATCH_CHAN <= TX_MATCH_CHAN;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  logic addr_wr;
  assign addr_wr = do_write && wd.strb[0] && wsel == txmp_pkg::SEL_ADDR;

  AST_TABLE_HOLDS: assert property (
    !addr_wr |=> $stable(table_mem[0]) && $stable(table_mem[1])
                 && $stable(table_mem[2]) && $stable(table_mem[3]))
    else $error("address table changed without an address write");
  AST_PTR_SET: assert property (
    do_write && wd.strb[0] && wsel == txmp_pkg::SEL_PTR
    |=> chan_ptr == $past(wd.data[4:0]))
    else $error("pointer not loaded from select write");
  AST_SEL_CH2: assert property (
    addr_wr && chan_ptr == 5'h02
    |=> table_mem[2] == $past(wd.data[4:0]) && $stable(table_mem[0]))
    else $error("select value 2 did not reach channel 2");
  AST_ADDR_STORE: assert property (
    addr_wr && chan_ptr <= `TXMP_PTR_MAX
    |=> table_mem[$past(chan_ptr[1:0])] == $past(wd.data[4:0]))
    else $error("address not stored into selected channel");
  AST_PTR_NO_TABLE: assert property (
    do_write && wsel != txmp_pkg::SEL_ADDR
    |=> $stable(table_mem[0]) && $stable(table_mem[1])
        && $stable(table_mem[2]) && $stable(table_mem[3]))
    else $error("non-address write disturbed the table");
  AST_TRISTATE: assert property (
    ctrl[`TXMP_MPHY_BIT] && !next_match.hit |=> TX_CLAV_OEN)
    else $error("cell-available driven on address mismatch");
  AST_MATCH_DRIVE: assert property (
    ctrl[`TXMP_MPHY_BIT] && next_match.hit
    |=> !TX_CLAV_OEN ##0 TX_CLAV == $past(TX_CELL_ROOM[next_match.chan]))
    else $error("matched channel did not drive cell-available");
  AST_SINGLE_PHY: assert property (
    !ctrl[`TXMP_MPHY_BIT] |=> !TX_CLAV_OEN && TX_MATCH_CHAN == 2'h0)
    else $error("single-phy mode did not drive channel 0");
  AST_HIGH_PTR: assert property (
    addr_wr && chan_ptr > `TXMP_PTR_MAX
    |=> $stable(table_mem[0]) && $stable(table_mem[1])
        && $stable(table_mem[2]) && $stable(table_mem[3]))
    else $error("write with pointer above 3 changed the table");
  AST_READ_UPPER: assert property (
    ARVALID && ARREADY && decode(ARADDR) == txmp_pkg::SEL_ADDR
    |=> RVALID && RDATA[31:5] == 27'h000_0000)
    else $error("address read shows nonzero upper bits");

  COV_ASSIGN: cover property (
    do_write && wsel == txmp_pkg::SEL_PTR ##[1:20] addr_wr);
  COV_POLL_HIT: cover property (
    ctrl[`TXMP_MPHY_BIT] && next_match.hit ##1 !TX_CLAV_OEN);
  COV_POLL_MISS: cover property (
    ctrl[`TXMP_MPHY_BIT] && !next_match.hit ##1 TX_CLAV_OEN);

endmodule : tx_multiphy_address_table

// ==== shared/txmp_defs.svh ====
// register map, field layout, reset values and response codes
`ifndef TXMP_DEFS_SVH
`define TXMP_DEFS_SVH

`define TXMP_ADDR_W        16
`define TXMP_DATA_W        32
`define TXMP_CHANNELS      4
`define TXMP_FIELD_W       5

// printed offsets are register indices; byte address is four times each
`define TXMP_CTRL_IDX      12'h483
`define TXMP_ADDR_IDX      12'h593
`define TXMP_PTR_IDX       12'h597
`define TXMP_BYTE(i)       ({2'b00, (i), 2'b00})

`define TXMP_MPHY_BIT      6
`define TXMP_CTRL_RESET    8'hcc
`define TXMP_PTR_RESET     5'h00
`define TXMP_UNASSIGNED    5'h1f
`define TXMP_PTR_MAX       5'h03

`define TXMP_RESP_OKAY     2'h0
`define TXMP_RESP_SLVERR   2'h2

`endif

// ==== shared/txmp_pkg.sv ====
// types shared by the transmit multi-phy address table
package txmp_pkg;

  typedef enum logic [3:0] {
    SEL_NONE = 4'h1,
    SEL_CTRL = 4'h2,
    SEL_ADDR = 4'h4,
    SEL_PTR  = 4'h8
  } reg_sel_t;

  typedef logic [4:0] tx_addr_t;

  typedef struct packed {
    logic     held;
    logic [15:0] addr;
  } addr_hold_t;

  typedef struct packed {
    logic        held;
    logic [31:0] data;
    logic [3:0]  strb;
  } data_hold_t;

  typedef struct packed {
    logic       hit;
    logic [1:0] chan;
  } match_t;

endpackage : txmp_pkg

// ==== tb/atm_poller.sv ====
// model of the atm layer processor polling the shared address bus
`timescale 1ns/1ps
module atm_poller (
  input  wire logic       CLK,
  input  wire logic [4:0] want,
  output logic      [4:0] bus_addr
);
  // launched after the edge, held a whole cycle like a real poller
  always_ff @(posedge CLK) begin
    bus_addr <= want;
  end
endmodule : atm_poller

// ==== tb/tx_multiphy_address_table_bench.sv ====
// register and poll bench for the transmit multi-phy address table
`timescale 1ns/1ps
`include "txmp_defs.svh"
module tx_multiphy_address_table_bench;
  localparam logic [15:0] A_CTRL = `TXMP_BYTE(`TXMP_CTRL_IDX);
  localparam logic [15:0] A_ADDR = `TXMP_BYTE(`TXMP_ADDR_IDX);
  localparam logic [15:0] A_PTR  = `TXMP_BYTE(`TXMP_PTR_IDX);
  logic        CLK = 0, SYS_RST = 1;
  logic [15:0] AWADDR = 0, ARADDR = 0;
  logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic [31:0] WDATA = 0, RDATA, d;
  logic [3:0]  WSTRB = 4'hf, TX_CELL_ROOM = 4'b0101;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_CLAV, TX_CLAV_OEN;
  logic [1:0]  BRESP, RRESP, TX_MATCH_CHAN, r;
  logic [4:0]  want = 5'h1f, TX_BUS_ADDR;
  int          n_checks = 0, n_mismatch = 0;

  always #12.5 CLK = ~CLK;

  tx_multiphy_address_table tx_multiphy_address_table_i (
    .CLK           (CLK),
    .SYS_RST       (SYS_RST),
    .AWADDR        (AWADDR),
    .AWVALID       (AWVALID),
    .AWREADY       (AWREADY),
    .WDATA         (WDATA),
    .WSTRB         (WSTRB),
    .WVALID        (WVALID),
    .WREADY        (WREADY),
    .BRESP         (BRESP),
    .BVALID        (BVALID),
    .BREADY        (BREADY),
    .ARADDR        (ARADDR),
    .ARVALID       (ARVALID),
    .ARREADY       (ARREADY),
    .RDATA         (RDATA),
    .RRESP         (RRESP),
    .RVALID        (RVALID),
    .RREADY        (RREADY),
    .TX_BUS_ADDR   (TX_BUS_ADDR),
    .TX_CELL_ROOM  (TX_CELL_ROOM),
    .TX_CLAV       (TX_CLAV),
    .TX_CLAV_OEN   (TX_CLAV_OEN),
    .TX_MATCH_CHAN (TX_MATCH_CHAN)
  );
  atm_poller atm_poller_i (.CLK(CLK), .want(want), .bus_addr(TX_BUS_ADDR));

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  // either channel may be taken first; bready held until the answer
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    int i;
    @(posedge CLK);
    AWADDR <= a; WDATA <= v; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
    for (i = 0; i < 40; i++) begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 0;
      if (WVALID && WREADY) WVALID <= 0;
      if (BVALID) break;
    end
    r = BRESP;
    BREADY <= 0;
    if (i == 40) begin n_mismatch++; final_report(); end
  endtask : wr

  task automatic rd(input logic [15:0] a);
    int i;
    @(posedge CLK);
    ARADDR <= a; ARVALID <= 1; RREADY <= 1;
    for (i = 0; i < 40; i++) begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 0;
      if (RVALID) break;
    end
    d = RDATA; r = RRESP;
    RREADY <= 0;
    if (i == 40) begin n_mismatch++; final_report(); end
  endtask : rd

  // one cycle in the poller, one in the table, then settled
  task automatic poll(input logic [4:0] v, input logic oen, clav,
                      input logic [1:0] ch);
    @(posedge CLK);
    want <= v;
    repeat (2) @(posedge CLK);
    #1;
    chk("oen", TX_CLAV_OEN, oen);
    chk("clav", TX_CLAV, clav);
    chk("chan", TX_MATCH_CHAN, ch);
  endtask : poll

  initial begin
    repeat (10) @(posedge CLK);
    SYS_RST <= 0;
    rd(A_PTR); chk("ptr", d, 32'h0000_0000);
    rd(A_ADDR); chk("addr", d, 32'h0000_001f);
    rd(A_CTRL); chk("ctrl", d, 32'h0000_00cc);
    // unique legal addresses, select always written before address
    for (int k = 0; k < 4; k++) begin
      wr(A_PTR, 32'(k));
      wr(A_ADDR, 32'h0000_00ea + 32'(k)); chk("bresp", r, 0);
    end
    for (int k = 0; k < 4; k++) begin
      wr(A_PTR, 32'(k));
      rd(A_ADDR); chk("entry", d, 32'h0000_000a + 32'(k));
    end
    wr(A_PTR, 32'h0000_0005);
    wr(A_ADDR, 32'h0000_001e);
    rd(A_ADDR); chk("ptr5", d, 32'h0000_0000);
    wr(A_PTR, 32'h0000_0000);
    rd(A_ADDR); chk("keep0", d, 32'h0000_000a);
    // lane 0 disabled: the select write must not move the pointer
    WSTRB <= 4'he;
    wr(A_PTR, 32'h0000_0002);
    WSTRB <= 4'hf;
    chk("strb_resp", r, `TXMP_RESP_OKAY);
    rd(A_PTR);
    chk("strb_ptr", d, 32'h0000_0000);
    wr(16'h0000, 32'h0000_0001); chk("unm_w", r, `TXMP_RESP_SLVERR);
    rd(16'h0004); chk("unm_r", r, `TXMP_RESP_SLVERR);
    chk("unm_d", d, 32'h0000_0000);
    for (int k = 0; k < 4; k++)
      poll(5'h0a + 5'(k), 1'b0, TX_CELL_ROOM[k], 2'(k));
    // inverted room pattern, so a fixed per-channel answer cannot pass
    @(posedge CLK);
    TX_CELL_ROOM <= 4'b1010;
    for (int k = 0; k < 4; k++)
      poll(5'h0a + 5'(k), 1'b0, 1'(k), 2'(k));
    poll(5'h1f, 1'b1, 1'b0, 2'h3);
    poll(5'h15, 1'b1, 1'b0, 2'h3);
    wr(A_CTRL, 32'h0000_008c);
    poll(5'h15, 1'b0, TX_CELL_ROOM[0], 2'h0);
    // mid-run reset: table back to unassigned, multi-phy mode back on
    @(posedge CLK);
    SYS_RST <= 1;
    repeat (2) @(posedge CLK);
    SYS_RST <= 0;
    rd(A_ADDR);
    chk("rst_addr", d, 32'h0000_001f);
    poll(5'h0a, 1'b1, 1'b0, 2'h0);
    final_report();
  end
endmodule : tx_multiphy_address_table_bench
